//--- pwc_power_ctrl.sv
// Purpose: Power state controller with sequencer and APB register slave
// Assumes: Supply comparators and requests synchronous to the clock
// Notes:   One sequence step per slow tick; supply loss overrides state, sequence, halt and rail modes
//
// Local design decisions: the APB slave port and the address map.

module pwc_power_ctrl #(
	parameter logic [pwc_pkg::CNT_W-1:0] TICK_CYCLES = pwc_pkg::CNT_W'(pwc_pkg::CLK_HZ / pwc_pkg::OSC_HZ),
	parameter pwc_pkg::pwc_crc_t         CRC_POLICY  = pwc_pkg::CRC_HALT
) (
	input  wire logic        clock,
	input  wire logic        reset,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        por_ok,
	input  wire logic        sys_above_low,
	input  wire logic        sense_above_high,
	input  wire logic        hot_die,
	input  wire logic        on_req,
	input  wire logic        off_req,
	input  wire logic        sleep_req,
	input  wire logic        wake_req,
	input  wire logic        irq_pending,
	input  wire logic [15:0] otp_sense,
	output logic [2:0]       power_state,
	output logic [15:0]      res_mode,
	output logic [3:0]       subsys_active,
	output logic             seq_busy,
	output logic             otp_error_irq
);
	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		pwc_pkg::pwc_pstate_t      pstate;
		pwc_pkg::pwc_pstate_t      target;
		pwc_pkg::pwc_seq_t         seq;
		logic                      run;
		logic                      stop_io;
		logic                      halted;
		logic                      otp_err;
		logic [1:0]                idx;
		logic [pwc_pkg::CNT_W-1:0] cnt;
		logic [15:0]               res;
		logic [15:0]               slp_cfg;
		logic [3:0]                sub;
		logic [31:0]               rdata;
	} pwc_state_t;

	pwc_state_t        st_ff;
	pwc_state_t        nxt_st;
	logic              arb_go;
	pwc_pkg::pwc_seq_t arb_seq;
	logic [2:0]        rom_res;
	logic [1:0]        rom_mode;
	logic              rom_last;
	logic              on_gate;
	logic              wr_en;
	logic              addr_hit;
	logic              crc_fail;
	logic [3:0]        link_term [pwc_pkg::NUM_RES];

	// ****************************************
	// Arbitration and sequence store
	// ****************************************
	// Low supply, hot die or a stopped power-up blocks switching on
	assign on_gate = !sense_above_high || hot_die || st_ff.halted;

	pwc_arbiter u_arb (
		.clock       (clock),
		.reset       (reset),
		.pstate      (st_ff.pstate),
		.busy        (st_ff.run),
		.off_req     (off_req),
		.on_req      (on_req),
		.sleep_req   (sleep_req),
		.wake_req    (wake_req),
		.on_gate     (on_gate),
		.irq_pending (irq_pending),
		.go          (arb_go),
		.seq         (arb_seq)
	);

	pwc_seq_rom u_rom (
		.clock     (clock),
		.reset     (reset),
		.seq       (st_ff.seq),
		.idx       (st_ff.idx),
		.step_res  (rom_res),
		.step_mode (rom_mode),
		.step_last (rom_last)
	);

	// ****************************************
	// Linked subsystems
	// ****************************************
	// Each resource that is on lights the subsystems mapped to it
	for (genvar r = 0; r < pwc_pkg::NUM_RES; r++) begin : g_link
		assign link_term[r] = (st_ff.res[2*r +: 2] == pwc_pkg::MODE_ON) ? pwc_pkg::LINK_MAP[4*r +: 4] : 4'h0;
	end

	// Decode shared by the bus and the check
	assign wr_en    = psel && penable && pwrite;
	assign addr_hit = (paddr == pwc_pkg::OFS_RES) || (paddr == pwc_pkg::OFS_SLP_CFG) ||
	                  (paddr == pwc_pkg::OFS_STATUS);
	assign crc_fail = (CRC_POLICY != pwc_pkg::CRC_SKIP) && (otp_sense != pwc_pkg::OTP_GOLDEN);

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		nxt_st = st_ff;

		// Host writes; resources only while powered up and idle
		if (wr_en && paddr == pwc_pkg::OFS_RES && !st_ff.run &&
		    (st_ff.pstate == pwc_pkg::PS_ACTIVE || st_ff.pstate == pwc_pkg::PS_SLEEP)) begin
			nxt_st.res = pwdata[15:0];
		end
		if (wr_en && paddr == pwc_pkg::OFS_SLP_CFG) begin
			nxt_st.slp_cfg = pwdata[15:0];
		end
		if (wr_en && paddr == pwc_pkg::OFS_STATUS && pwdata[pwc_pkg::ST_ERR_BIT]) begin
			nxt_st.otp_err = 1'b0;
		end
		if (off_req) begin
			nxt_st.halted = 1'b0;
		end

		// Start a transition from the arbiter
		if (arb_go) begin
			nxt_st.run     = 1'b1;
			nxt_st.seq     = arb_seq;
			nxt_st.idx     = 2'h0;
			nxt_st.cnt     = '0;
			nxt_st.stop_io = 1'b0;
			case (arb_seq)
				pwc_pkg::SQ_OFF_ACT, pwc_pkg::SQ_SLP_ACT: nxt_st.target = pwc_pkg::PS_ACTIVE;
				pwc_pkg::SQ_ACT_SLP: nxt_st.target = pwc_pkg::PS_SLEEP;
				default: nxt_st.target = pwc_pkg::PS_OFF;
			endcase
			// Integrity check; set beats a same-cycle software clear
			if (arb_seq == pwc_pkg::SQ_OFF_ACT && crc_fail) begin
				nxt_st.otp_err = 1'b1;
				case (CRC_POLICY)
					pwc_pkg::CRC_HALT: begin
						nxt_st.run    = 1'b0;
						nxt_st.halted = 1'b1;
					end
					pwc_pkg::CRC_STOP_IO: nxt_st.stop_io = 1'b1;
					default: nxt_st.stop_io = 1'b0;
				endcase
			end
		end else if (st_ff.run) begin
			// One step per slow tick; the store needs one cycle to settle
			if (st_ff.cnt == TICK_CYCLES - pwc_pkg::CNT_W'(1)) begin
				nxt_st.cnt = '0;
				nxt_st.idx = st_ff.idx + 2'h1;
				if (st_ff.seq == pwc_pkg::SQ_ACT_SLP) begin
					nxt_st.res[{rom_res, 1'b0} +: 2] = st_ff.slp_cfg[{rom_res, 1'b0} +: 2];
				end else begin
					nxt_st.res[{rom_res, 1'b0} +: 2] = rom_mode;
				end
				if (st_ff.stop_io && rom_res == pwc_pkg::IO_RES) begin
					// Power-up stops here with the I/O rail up
					nxt_st.run    = 1'b0;
					nxt_st.halted = 1'b1;
				end else if (rom_last) begin
					nxt_st.run    = 1'b0;
					nxt_st.pstate = st_ff.target;
					if (st_ff.target == pwc_pkg::PS_OFF) begin
						nxt_st.res = st_ff.res & pwc_pkg::RES_AON_MSK;
					end
				end
			end else begin
				nxt_st.cnt = st_ff.cnt + pwc_pkg::CNT_W'(1);
			end
		end

		// Supply levels win over any sequence in flight
		if (!por_ok) begin
			nxt_st.pstate = pwc_pkg::PS_NOSUP;
			nxt_st.run    = 1'b0;
			nxt_st.halted = 1'b0;
			nxt_st.res    = pwc_pkg::RES_RST;
		end else if (!sys_above_low) begin
			nxt_st.pstate = pwc_pkg::PS_BACKUP;
			nxt_st.run    = 1'b0;
			nxt_st.halted = 1'b0;
			nxt_st.res    = pwc_pkg::RES_RST;
		end else if (st_ff.pstate == pwc_pkg::PS_NOSUP || st_ff.pstate == pwc_pkg::PS_BACKUP) begin
			// Hardware entry into off, no sequence involved
			nxt_st.pstate = pwc_pkg::PS_OFF;
			nxt_st.res    = pwc_pkg::RES_RST;
		end

		// Subsystems follow the rails one cycle later
		nxt_st.sub = 4'h0;
		for (int r = 0; r < pwc_pkg::NUM_RES; r++) begin
			nxt_st.sub = nxt_st.sub | link_term[r];
		end

		// Read data is latched in the setup phase
		if (psel && !penable) begin
			case (paddr)
				pwc_pkg::OFS_RES:     nxt_st.rdata = {16'h0000, st_ff.res};
				pwc_pkg::OFS_SLP_CFG: nxt_st.rdata = {16'h0000, st_ff.slp_cfg};
				pwc_pkg::OFS_STATUS: begin
					nxt_st.rdata                       = {29'h0000_0000, st_ff.pstate};
					nxt_st.rdata[pwc_pkg::ST_BUSY_BIT] = st_ff.run;
					nxt_st.rdata[pwc_pkg::ST_ERR_BIT]  = st_ff.otp_err;
					nxt_st.rdata[pwc_pkg::ST_HALT_BIT] = st_ff.halted;
				end
				default: nxt_st.rdata = 32'h0000_0000;
			endcase
		end
	end

	// ****************************************
	// Registers
	// ****************************************
	always_ff @(posedge clock) begin
		if (reset) begin
			st_ff         <= '0;
			st_ff.pstate  <= pwc_pkg::PS_NOSUP;
			st_ff.target  <= pwc_pkg::PS_NOSUP;
			st_ff.seq     <= pwc_pkg::SQ_NONE;
			st_ff.res     <= pwc_pkg::RES_RST;
			st_ff.slp_cfg <= pwc_pkg::SLP_CFG_RST;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	// Zero wait states keeps the bus simple
	assign pready        = 1'b1;
	assign pslverr       = psel && penable && !addr_hit;
	assign prdata        = st_ff.rdata;
	assign power_state   = st_ff.pstate;
	assign res_mode      = st_ff.res;
	assign subsys_active = st_ff.sub;
	assign seq_busy      = st_ff.run;
	assign otp_error_irq = st_ff.otp_err;

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (reset);

	sequence s_crc_fail;
		arb_go && arb_seq == pwc_pkg::SQ_OFF_ACT && crc_fail && por_ok && sys_above_low;
	endsequence

	sequence s_idle_powered;
		!st_ff.run && por_ok && sys_above_low && !arb_go &&
		(st_ff.pstate == pwc_pkg::PS_OFF || st_ff.pstate == pwc_pkg::PS_ACTIVE ||
		 st_ff.pstate == pwc_pkg::PS_SLEEP);
	endsequence

	a_nosup_state: assert property (!por_ok |=> st_ff.pstate == pwc_pkg::PS_NOSUP)
		else $error("no supply state not taken");
	a_backup_state: assert property (por_ok && !sys_above_low |=> st_ff.pstate == pwc_pkg::PS_BACKUP)
		else $error("backup state not taken");
	a_no_seq_low: assert property ((st_ff.pstate == pwc_pkg::PS_NOSUP || st_ff.pstate == pwc_pkg::PS_BACKUP)
		|-> !st_ff.run)
		else $error("sequence running without supply");
	a_off_rails: assert property (st_ff.pstate == pwc_pkg::PS_OFF && !st_ff.run && !st_ff.halted
		|-> (st_ff.res & ~pwc_pkg::RES_AON_MSK) == 16'h0000)
		else $error("rail on in off state");
	a_active_entry: assert property ($rose(st_ff.pstate == pwc_pkg::PS_ACTIVE)
		|-> $past(st_ff.run) && ($past(st_ff.seq) == pwc_pkg::SQ_OFF_ACT ||
		$past(st_ff.seq) == pwc_pkg::SQ_SLP_ACT))
		else $error("active entered without power-up sequence");
	a_hold_state: assert property (s_idle_powered |=> $stable(st_ff.pstate))
		else $error("state changed while idle");
	a_off_first: assert property (arb_go && $past(off_req)
		|-> arb_seq == pwc_pkg::SQ_ACT_OFF || arb_seq == pwc_pkg::SQ_SLP_OFF)
		else $error("off request lost priority");
	a_sleep_gate: assert property (arb_go && arb_seq == pwc_pkg::SQ_ACT_SLP |-> $past(!irq_pending))
		else $error("sleep taken with interrupt pending");
	a_otp_irq: assert property (s_crc_fail |=> otp_error_irq ##1 otp_error_irq)
		else $error("integrity interrupt missing");
	a_crc_halt: assert property (s_crc_fail ##0 (CRC_POLICY == pwc_pkg::CRC_HALT) |=> !st_ff.run [*3])
		else $error("power-up not halted on integrity error");
	a_step_pace: assert property (st_ff.run && $changed(st_ff.idx) |=> $stable(st_ff.idx) [*2])
		else $error("sequence steps too close");

endmodule : pwc_power_ctrl

//--- pwc_pkg.sv
// Purpose: Shared types and constants of the power state controller
// Assumes: 200 MHz system clock, APB register access
// Notes:   Sequence contents and integrity policy are fixed at build time
package pwc_pkg;

	// ****************************************
	// Types
	// ****************************************
	typedef enum logic [2:0] {PS_NOSUP, PS_BACKUP, PS_OFF, PS_ACTIVE, PS_SLEEP} pwc_pstate_t;
	typedef enum logic [2:0] {SQ_NONE, SQ_OFF_ACT, SQ_ACT_OFF, SQ_ACT_SLP, SQ_SLP_ACT, SQ_SLP_OFF} pwc_seq_t;
	typedef enum logic [1:0] {CRC_SKIP, CRC_IGNORE, CRC_STOP_IO, CRC_HALT} pwc_crc_t;

	// ****************************************
	// Resources and modes
	// ****************************************
	localparam int         NUM_RES      = 8;
	localparam int         NUM_SUB      = 4;
	localparam logic [1:0] MODE_OFF     = 2'h0;
	localparam logic [1:0] MODE_SLEEP   = 2'h1;
	localparam logic [1:0] MODE_ON      = 2'h2;
	localparam logic [2:0] AON_RES      = 3'h0;
	localparam logic [2:0] IO_RES       = 3'h1;
	localparam logic [1:0] LAST_STEP    = 2'h3;
	localparam logic [31:0] LINK_MAP    = 32'h0000_8421;

	// ****************************************
	// Register map and reset values
	// ****************************************
	localparam logic [11:0] OFS_RES     = 12'h000;
	localparam logic [11:0] OFS_SLP_CFG = 12'h004;
	localparam logic [11:0] OFS_STATUS  = 12'h008;
	localparam int          ST_BUSY_BIT = 4;
	localparam int          ST_ERR_BIT  = 8;
	localparam int          ST_HALT_BIT = 9;
	localparam logic [15:0] RES_RST     = 16'h0002;
	localparam logic [15:0] SLP_CFG_RST = 16'h0002;
	localparam logic [15:0] RES_AON_MSK = 16'h0003;
	localparam logic [15:0] OTP_GOLDEN  = 16'h5A3C;

	// ****************************************
	// Timing
	// ****************************************
	localparam int CLK_HZ = 200_000_000;
	localparam int OSC_HZ = 32_768;
	localparam int CNT_W  = 13;

endpackage : pwc_pkg

//--- pwc_seq_rom.sv
// Purpose: Fixed store of the five power sequences, one step per read
// Assumes: Four steps per sequence, step data one clock after index
// Notes:   Contents are constants, software cannot alter them
module pwc_seq_rom (
	input  wire logic              clock,
	input  wire logic              reset,
	input  wire pwc_pkg::pwc_seq_t seq,
	input  wire logic [1:0]        idx,
	output logic [2:0]             step_res,
	output logic [1:0]             step_mode,
	output logic                   step_last
);
	typedef struct packed {
		logic [2:0] res;
		logic [1:0] mode;
		logic       last;
	} pwc_rom_t;

	pwc_rom_t rom_ff;
	pwc_rom_t nxt_rom;

	// ****************************************
	// Step table
	// ****************************************
	// Power-up walks rails upward, power-down walks them back down
	always_comb begin
		nxt_rom.last = (idx == pwc_pkg::LAST_STEP);
		nxt_rom.res  = 3'(idx) + 3'h1;
		nxt_rom.mode = pwc_pkg::MODE_ON;
		case (seq)
			pwc_pkg::SQ_OFF_ACT, pwc_pkg::SQ_SLP_ACT: begin
				nxt_rom.mode = pwc_pkg::MODE_ON;
			end
			pwc_pkg::SQ_ACT_OFF, pwc_pkg::SQ_SLP_OFF: begin
				nxt_rom.res  = 3'h4 - 3'(idx);
				nxt_rom.mode = pwc_pkg::MODE_OFF;
			end
			pwc_pkg::SQ_ACT_SLP: begin
				nxt_rom.res  = 3'h4 - 3'(idx);
				nxt_rom.mode = pwc_pkg::MODE_SLEEP;
			end
			default: begin
				nxt_rom.res  = pwc_pkg::AON_RES;
				nxt_rom.last = 1'b1;
			end
		endcase
	end

	// Registered read, like a real fuse array
	always_ff @(posedge clock) begin
		if (reset) begin
			rom_ff <= '0;
		end else begin
			rom_ff <= nxt_rom;
		end
	end

	assign step_res  = rom_ff.res;
	assign step_mode = rom_ff.mode;
	assign step_last = rom_ff.last;

endmodule : pwc_seq_rom

//--- pwc_arbiter.sv
// Purpose: Ranks on, off, sleep and wake requests into one transition
// Assumes: Requests are levels synchronous to the clock
// Notes:   Issues at most one transition while the sequencer is idle
module pwc_arbiter (
	input  wire logic                 clock,
	input  wire logic                 reset,
	input  wire pwc_pkg::pwc_pstate_t pstate,
	input  wire logic                 busy,
	input  wire logic                 off_req,
	input  wire logic                 on_req,
	input  wire logic                 sleep_req,
	input  wire logic                 wake_req,
	input  wire logic                 on_gate,
	input  wire logic                 irq_pending,
	output logic                      go,
	output pwc_pkg::pwc_seq_t         seq
);
	typedef struct packed {
		logic              go;
		pwc_pkg::pwc_seq_t seq;
	} pwc_arb_t;

	pwc_arb_t arb_ff;
	pwc_arb_t nxt_arb;

	// ****************************************
	// Ranking
	// ****************************************
	// Off outranks all; the go guard stops a second issue before busy rises
	always_comb begin
		nxt_arb.go  = 1'b0;
		nxt_arb.seq = pwc_pkg::SQ_NONE;
		if (!busy && !arb_ff.go) begin
			case (pstate)
				pwc_pkg::PS_OFF: begin
					if (!off_req && on_req && !on_gate) begin
						nxt_arb.go  = 1'b1;
						nxt_arb.seq = pwc_pkg::SQ_OFF_ACT;
					end
				end
				pwc_pkg::PS_ACTIVE: begin
					if (off_req) begin
						nxt_arb.go  = 1'b1;
						nxt_arb.seq = pwc_pkg::SQ_ACT_OFF;
					end else if (sleep_req && !irq_pending) begin
						nxt_arb.go  = 1'b1;
						nxt_arb.seq = pwc_pkg::SQ_ACT_SLP;
					end
				end
				pwc_pkg::PS_SLEEP: begin
					if (off_req) begin
						nxt_arb.go  = 1'b1;
						nxt_arb.seq = pwc_pkg::SQ_SLP_OFF;
					end else if (wake_req) begin
						nxt_arb.go  = 1'b1;
						nxt_arb.seq = pwc_pkg::SQ_SLP_ACT;
					end
				end
				default: begin
					nxt_arb.go = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			arb_ff <= '0;
		end else begin
			arb_ff <= nxt_arb;
		end
	end

	assign go  = arb_ff.go;
	assign seq = arb_ff.seq;

endmodule : pwc_arbiter

//--- pwc_rail_model.sv
// Purpose: Model of the switched rails that the controller drives
// Assumes: A rail is up one clock after its mode field reads on
// Notes:   Sleep and off both count as rail down
module pwc_rail_model (
	input  wire logic        clock,
	input  wire logic        reset,
	input  wire logic [15:0] res_mode,
	output logic [7:0]       rail_up,
	output logic             io_rail_up
);
	// ****************************************
	// Rail state
	// ****************************************
	logic [7:0] rail_ff;
	logic [7:0] nxt_rail;

	// Rails follow the mode bits alone, so no side path can switch them
	always_comb begin
		for (int r = 0; r < pwc_pkg::NUM_RES; r++) begin
			nxt_rail[r] = (res_mode[2*r +: 2] == pwc_pkg::MODE_ON);
		end
	end

	// One clock of settling, like a real regulator it never reacts at once
	always_ff @(posedge clock) begin
		if (reset) begin
			rail_ff <= 8'h00;
		end else begin
			rail_ff <= nxt_rail;
		end
	end

	assign rail_up    = rail_ff;
	assign io_rail_up = rail_ff[pwc_pkg::IO_RES];
endmodule : pwc_rail_model

//--- power_state_controller_tb.sv
// Purpose: Self-checking bench of the power state controller
// Assumes: Short slow tick of four clocks, default integrity policy
// Notes:   Requests are levels held until the sequence completes
module power_state_controller_tb;
	timeunit 1ns;
	timeprecision 100ps;

	// ****************************************
	// Signals
	// ****************************************
	typedef struct packed {
		logic       por;
		logic       low;
		logic [3:0] req;
		logic [2:0] st;
		logic [15:0] res;
		logic [3:0] sub;
	} pwc_tb_row_t;

	logic        clock, reset, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic        por_ok, sys_above_low, sense_above_high, hot_die, er;
	logic        on_req, off_req, sleep_req, wake_req, irq_pending;
	logic [15:0] otp_sense, res_mode;
	logic [2:0]  power_state, prev;
	logic [3:0]  subsys_active;
	logic        seq_busy, otp_error_irq, io_rail_up;
	// Bus handshake seen at the access edge
	logic        rdy;
	logic [7:0]  rail_up;
	int          fails, total_checks;

	// Request bits are {wake, sleep, off, on}
	pwc_tb_row_t rows [10] = '{
		'{1'b0, 1'b0, 4'h0, 3'h0, 16'h0002, 4'h1},
		'{1'b1, 1'b0, 4'h0, 3'h1, 16'h0002, 4'h1},
		'{1'b1, 1'b1, 4'h0, 3'h2, 16'h0002, 4'h1},
		'{1'b1, 1'b1, 4'h1, 3'h3, 16'h02AA, 4'hF},
		'{1'b1, 1'b1, 4'h4, 3'h4, 16'h0002, 4'h1},
		'{1'b1, 1'b1, 4'h8, 3'h3, 16'h02AA, 4'hF},
		'{1'b1, 1'b1, 4'h2, 3'h2, 16'h0002, 4'h1},
		'{1'b1, 1'b1, 4'h1, 3'h3, 16'h02AA, 4'hF},
		'{1'b1, 1'b1, 4'h4, 3'h4, 16'h0002, 4'h1},
		'{1'b1, 1'b1, 4'h2, 3'h2, 16'h0002, 4'h1}
	};

	pwc_power_ctrl #(.TICK_CYCLES(13'h4)) pwc_power_ctrl_inst (
		.clock(clock), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.por_ok(por_ok), .sys_above_low(sys_above_low), .sense_above_high(sense_above_high),
		.hot_die(hot_die), .on_req(on_req), .off_req(off_req), .sleep_req(sleep_req),
		.wake_req(wake_req), .irq_pending(irq_pending), .otp_sense(otp_sense),
		.power_state(power_state), .res_mode(res_mode), .subsys_active(subsys_active),
		.seq_busy(seq_busy), .otp_error_irq(otp_error_irq)
	);

	pwc_rail_model pwc_rail_model_inst (
		.clock(clock), .reset(reset), .res_mode(res_mode), .rail_up(rail_up), .io_rail_up(io_rail_up)
	);

	// ****************************************
	// Tasks
	// ****************************************
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fails++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	// Bounded wait, a hang shows up as a mismatch
	task automatic wait_busy(input logic lvl);
		int n;
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (seq_busy !== lvl && n < 100);
		chk(seq_busy, lvl);
	endtask : wait_busy

	// APB transfer, entered just after a rising edge
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
		int n;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge clock);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (pready !== 1'b1 && n < 50);
		rd = prdata;
		er = pslverr;
		rdy = pready;
		psel <= 1'b0;
		penable <= 1'b0;
		// Idle edge, so a following call never reassigns psel in this step
		@(posedge clock);
		chk(rdy, 1'b1);
	endtask : apb

	task automatic print_verdict();
		if (fails == 0 && total_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : print_verdict

	// ****************************************
	// Clock and watchdog
	// ****************************************
	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end

	// Whole run is well under a thousand clocks
	initial begin
		repeat (5000) @(posedge clock);
		fails++;
		print_verdict();
	end

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		fails = 0;
		total_checks = 0;
		{reset, por_ok, sys_above_low, sense_above_high} = 4'hF;
		{psel, penable, pwrite, hot_die, irq_pending} = 5'h00;
		{on_req, off_req, sleep_req, wake_req} = 4'h0;
		paddr = 12'h000;
		pwdata = 32'h0;
		otp_sense = pwc_pkg::OTP_GOLDEN;
		repeat (4) @(posedge clock);
		chk(power_state, 32'h0);
		chk(res_mode, 32'h0002);
		chk({seq_busy, otp_error_irq}, 32'h0);
		reset <= 1'b0;
		repeat (3) @(posedge clock);
		chk(power_state, 32'h2);
		prev = 3'h2;
		// Table of supply levels and transitions
		foreach (rows[i]) begin
			por_ok <= rows[i].por;
			sys_above_low <= rows[i].low;
			{wake_req, sleep_req, off_req, on_req} <= rows[i].req;
			if (rows[i].req != 4'h0) begin
				wait_busy(1'b1);
				chk(power_state, prev);
				wait_busy(1'b0);
				{wake_req, sleep_req, off_req, on_req} <= 4'h0;
			end
			repeat (4) @(posedge clock);
			chk(power_state, rows[i].st);
			chk(res_mode, rows[i].res);
			chk(subsys_active, rows[i].sub);
			prev = rows[i].st;
		end
		// Gated power-up, then off holding on back
		hot_die <= 1'b1;
		on_req <= 1'b1;
		repeat (30) @(posedge clock);
		chk(power_state, 32'h2);
		hot_die <= 1'b0;
		sense_above_high <= 1'b0;
		repeat (30) @(posedge clock);
		chk(power_state, 32'h2);
		off_req <= 1'b1;
		sense_above_high <= 1'b1;
		repeat (30) @(posedge clock);
		chk(power_state, 32'h2);
		off_req <= 1'b0;
		wait_busy(1'b1);
		wait_busy(1'b0);
		on_req <= 1'b0;
		repeat (2) @(posedge clock);
		chk(power_state, 32'h3);
		// Registers, unmapped place included
		apb(1'b1, pwc_pkg::OFS_SLP_CFG, 32'h0000021A);
		apb(1'b0, pwc_pkg::OFS_SLP_CFG, 32'h0);
		chk(rd, 32'h0000021A);
		apb(1'b0, pwc_pkg::OFS_STATUS, 32'h0);
		chk(rd, 32'h00000003);
		apb(1'b0, 12'h00C, 32'h0);
		chk({er, rd[30:0]}, 32'h80000000);
		apb(1'b1, pwc_pkg::OFS_RES, 32'h000000AA);
		repeat (2) @(posedge clock);
		chk(res_mode, 32'h00AA);
		// Sleep held off by a pending interrupt
		irq_pending <= 1'b1;
		sleep_req <= 1'b1;
		repeat (30) @(posedge clock);
		chk(power_state, 32'h3);
		irq_pending <= 1'b0;
		wait_busy(1'b1);
		wait_busy(1'b0);
		sleep_req <= 1'b0;
		repeat (2) @(posedge clock);
		chk(power_state, 32'h4);
		chk(res_mode, 32'h021A);
		chk(subsys_active, 32'h3);
		// Off and wake together in sleep: off wins
		off_req <= 1'b1;
		wake_req <= 1'b1;
		wait_busy(1'b1);
		wait_busy(1'b0);
		{off_req, wake_req} <= 2'h0;
		repeat (2) @(posedge clock);
		chk(power_state, 32'h2);
		chk(rail_up, 32'h01);
		chk(io_rail_up, 32'h0);
		// Integrity error halts power-up
		otp_sense <= 16'h0000;
		on_req <= 1'b1;
		repeat (30) @(posedge clock);
		on_req <= 1'b0;
		chk(power_state, 32'h2);
		chk(res_mode, 32'h0002);
		chk(otp_error_irq, 32'h1);
		apb(1'b0, pwc_pkg::OFS_STATUS, 32'h0);
		chk(rd & 32'h300, 32'h300);
		apb(1'b1, pwc_pkg::OFS_STATUS, 32'h00000100);
		repeat (2) @(posedge clock);
		chk(otp_error_irq, 32'h0);
		// Halt cleared by off, then supply lost in mid-sequence
		otp_sense <= pwc_pkg::OTP_GOLDEN;
		off_req <= 1'b1;
		repeat (2) @(posedge clock);
		off_req <= 1'b0;
		on_req <= 1'b1;
		wait_busy(1'b1);
		repeat (6) @(posedge clock);
		por_ok <= 1'b0;
		repeat (2) @(posedge clock);
		chk(res_mode, 32'h0002);
		chk(power_state, 32'h0);
		print_verdict();
	end
endmodule : power_state_controller_tb
